// *** hdl/fgs_regs.svh ***
// register offsets, field positions, reset values and timing counts of the gateway
`ifndef FGS_REGS_SVH
`define FGS_REGS_SVH
`define FGS_OFS_STATUS 5'h00
`define FGS_OFS_CONFIG 5'h04
`define FGS_OFS_CTRL 5'h08
`define FGS_OFS_IRQ_STAT 5'h0c
`define FGS_OFS_IRQ_MASK 5'h10
`define FGS_OFS_TBL_PTR 5'h14
`define FGS_OFS_TBL_DATA 5'h18
`define FGS_ST_OUTPUT_FAULT 0
`define FGS_ST_INPUT_FAULT 1
`define FGS_ST_GENERAL_FAULT 2
`define FGS_ST_DIAGNOSTIC 3
`define FGS_ST_RUN 4
`define FGS_ST_EXCHANGE 5
`define FGS_IRQ_POLL_DONE 0
`define FGS_IRQ_MASTER_DATA 1
`define FGS_IRQ_CFG_ERROR 2
`define FGS_IRQ_EXCH_LOST 3
`define FGS_IRQ_BAD_POLL 4
`define FGS_IRQ_W 5
`define FGS_CTRL_RESET 1'b1
`define FGS_MASK_RESET 5'h00
`define FGS_CLK_MHZ 25
`define FGS_CFG_TIME_NS 400
`define FGS_CFG_CYC ((`FGS_CFG_TIME_NS * `FGS_CLK_MHZ + 999) / 1000)
`define FGS_EXCH_TIMEOUT_US 100000
`define FGS_EXCH_TIMEOUT_CYC (`FGS_EXCH_TIMEOUT_US * `FGS_CLK_MHZ)
`define FGS_REPLY_BYTES 15
`define FGS_POINTS 128
`endif

// *** hdl/fgs_pkg.sv ***
// types shared by the gateway modules
package fgs_pkg;
   typedef enum logic [2:0] {
      CFG_START,
      CFG_CHECK,
      CFG_RUN,
      CFG_FAULT
   } fgs_cfg_state_t;
   typedef enum logic [1:0] {
      POLL_IDLE,
      POLL_ISSUE,
      POLL_LOAD,
      POLL_SEND
   } fgs_poll_state_t;
   typedef logic [3:0] fgs_digit_t;
   typedef logic [7:0] fgs_byte_t;
   typedef logic [127:0] fgs_points_t;
endpackage : fgs_pkg

// *** hdl/fgs_table_mem.sv ***
// byte-wide payload table memory with registered read data
`timescale 1ns/1ps
module fgs_table_mem #(
   parameter int ADDR_BITS = 9
) (
   input wire logic sys_clk,
   input wire logic wr_en,
   input wire logic [ADDR_BITS-1:0] wr_addr,
   input wire fgs_pkg::fgs_byte_t wr_data,
   input wire logic rd_en,
   input wire logic [ADDR_BITS-1:0] rd_addr,
   output fgs_pkg::fgs_byte_t rd_data
);
   import fgs_pkg::*;
   // no reset on the array: contents are defined by software before polls are served
   fgs_byte_t mem [0:(1<<ADDR_BITS)-1];
   fgs_byte_t rd_data_reg;
   always_ff @(posedge sys_clk)
   begin
      if (wr_en)
      begin
         mem[wr_addr] <= wr_data;
      end
      if (rd_en)
      begin
         rd_data_reg <= mem[rd_addr];
      end
   end
   assign rd_data = rd_data_reg;
endmodule : fgs_table_mem

// *** hdl/fgs_gateway.sv ***
// fieldbus gateway: switch decode, start-up, data exchange, status byte, payload polls
//
// Added by the designer: register access over Avalon-MM and the address map.
`timescale 1ns/1ps
`include "fgs_regs.svh"
module fgs_gateway #(
   parameter int TABLE_BITS = 2,
   parameter int SEG_BITS = 3,
   parameter int EXCH_TIMEOUT_CYC = `FGS_EXCH_TIMEOUT_CYC
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic irq,
   input wire fgs_pkg::fgs_digit_t rate_selector_switch,
   input wire fgs_pkg::fgs_digit_t tens_digit_switch,
   input wire fgs_pkg::fgs_digit_t units_digit_switch,
   output logic bus_enable,
   output logic [6:0] station_address,
   output logic [9:0] bit_rate_kbps,
   input wire logic output_fault_bit,
   input wire logic input_fault_bit,
   input wire logic general_fault_bit,
   input wire logic diagnostic_bit,
   input wire logic run_bit,
   output fgs_pkg::fgs_byte_t status_byte,
   input wire logic master_out_valid,
   input wire fgs_pkg::fgs_points_t master_out_data,
   output fgs_pkg::fgs_points_t base_input_area,
   input wire fgs_pkg::fgs_points_t base_output_area,
   output fgs_pkg::fgs_points_t master_in_data,
   input wire logic poll_valid,
   input wire fgs_pkg::fgs_byte_t poll_table,
   input wire fgs_pkg::fgs_byte_t poll_segment,
   output logic poll_ready,
   output logic reply_valid,
   output fgs_pkg::fgs_byte_t reply_byte,
   output logic reply_last,
   input wire logic reply_ready,
   output logic power_led,
   output logic run_led,
   output logic error_led
);
   import fgs_pkg::*;
   localparam int ADDR_BITS = TABLE_BITS + SEG_BITS + 4;
   localparam int TW = $clog2(EXCH_TIMEOUT_CYC + 1);
   localparam int CFG_CYC = `FGS_CFG_CYC;
   localparam int IW = `FGS_IRQ_W;
   generate
      if (TABLE_BITS < 1 || TABLE_BITS > 8 || SEG_BITS < 1 || SEG_BITS > 8 || EXCH_TIMEOUT_CYC < 1)
      begin : g_bad_param
         $error("fgs_gateway: table or segment width or timeout out of range");
      end
   endgenerate

   typedef struct packed {
      fgs_cfg_state_t cfg;
      logic [3:0] cfg_cnt;
      logic [6:0] station;
      logic [9:0] rate;
      logic powered;
      logic ctrl_en;
      logic [IW-1:0] irq_stat;
      logic [IW-1:0] irq_mask;
      logic [ADDR_BITS-1:0] tbl_ptr;
      logic ack;
      logic [31:0] rdata;
      fgs_poll_state_t poll;
      logic [3:0] byte_cnt;
      logic [TABLE_BITS-1:0] ptable;
      logic [SEG_BITS-1:0] pseg;
      logic poll_bad;
      fgs_byte_t reply;
      fgs_points_t to_base;
      fgs_points_t to_master;
      logic [TW-1:0] exch_timer;
      logic was_active;
   } fgs_state_t;

   fgs_state_t state_reg;
   fgs_state_t state_next;
   logic [1:0] rst_sync_reg;
   logic rst_int_n;
   logic mem_wr_en;
   logic mem_rd_en;
   logic [ADDR_BITS-1:0] mem_rd_addr;
   fgs_byte_t mem_rd_data;

   // reset is released through two flops so the release is clean on sys_clk
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rst_sync_reg <= 2'b00;
      end
      else
      begin
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
      end
   end
   assign rst_int_n = rst_sync_reg[1];

   function automatic logic [9:0] rate_of(input fgs_digit_t sel);
      case (sel)
         4'h1: rate_of = 10'h00a;
         4'h2: rate_of = 10'h014;
         4'h3: rate_of = 10'h032;
         4'h4: rate_of = 10'h07d;
         4'h5: rate_of = 10'h0fa;
         4'h6: rate_of = 10'h1f4;
         4'h7: rate_of = 10'h320;
         4'h8: rate_of = 10'h3e8;
         default: rate_of = 10'h000;
      endcase
   endfunction : rate_of

   logic req;
   logic done;
   logic [31:0] wmask;
   logic [31:0] wval;
   logic exch_active;
   logic running;
   logic poll_take;
   logic [IW-1:0] ev;
   fgs_byte_t status_now;

   assign req = avs_read | avs_write;
   assign done = req & state_reg.ack;
   assign avs_waitrequest = req & ~state_reg.ack;
   assign avs_readdata = state_reg.rdata;
   assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}}, {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
   assign wval = avs_writedata & wmask;
   assign running = (state_reg.cfg == CFG_RUN);
   assign exch_active = running && (state_reg.exch_timer != '0);
   assign poll_ready = (state_reg.poll == POLL_IDLE) && running;
   assign poll_take = poll_valid && poll_ready;
   assign mem_wr_en = done && avs_write && (avs_address == `FGS_OFS_TBL_DATA) && avs_byteenable[0];

   always_comb
   begin
      status_now = 8'h00;
      status_now[`FGS_ST_OUTPUT_FAULT] = output_fault_bit;
      status_now[`FGS_ST_INPUT_FAULT] = input_fault_bit;
      status_now[`FGS_ST_GENERAL_FAULT] = general_fault_bit;
      status_now[`FGS_ST_DIAGNOSTIC] = diagnostic_bit;
      status_now[`FGS_ST_RUN] = run_bit;
      status_now[`FGS_ST_EXCHANGE] = exch_active;
   end

   always_comb
   begin
      state_next = state_reg;
      ev = '0;
      mem_rd_en = 1'b0;
      mem_rd_addr = {state_reg.ptable, state_reg.pseg, state_reg.byte_cnt};
      state_next.powered = 1'b1;

      case (state_reg.cfg)
         CFG_START:
         begin
            state_next.cfg_cnt = state_reg.cfg_cnt + 4'h1;
            if (state_reg.cfg_cnt == 4'(CFG_CYC - 1))
            begin
               state_next.cfg = CFG_CHECK;
            end
         end
         CFG_CHECK:
         begin
            // station address from the two digit switches
            state_next.station = 7'(tens_digit_switch) * 7'h0a + 7'(units_digit_switch);
            state_next.rate = rate_of(rate_selector_switch);
            // invalid rate or digit keeps the block off the bus
            if (rate_of(rate_selector_switch) == 10'h000 || tens_digit_switch > 4'h9 || units_digit_switch > 4'h9)
            begin
               state_next.cfg = CFG_FAULT;
               ev[`FGS_IRQ_CFG_ERROR] = 1'b1;
            end
            else
            begin
               state_next.cfg = CFG_RUN;
            end
         end
         CFG_RUN:
         begin
         end
         CFG_FAULT:
         begin
         end
         default:
         begin
            state_next.cfg = CFG_START;
         end
      endcase

      // master outputs into controller input area
      if (running && state_reg.ctrl_en && master_out_valid)
      begin
         state_next.to_base = master_out_data;
         state_next.exch_timer = TW'(EXCH_TIMEOUT_CYC);
         state_next.was_active = 1'b1;
         ev[`FGS_IRQ_MASTER_DATA] = 1'b1;
      end
      else if (state_reg.exch_timer != '0)
      begin
         state_next.exch_timer = state_reg.exch_timer - TW'(1);
         if (state_reg.exch_timer == TW'(1))
         begin
            ev[`FGS_IRQ_EXCH_LOST] = 1'b1;
         end
      end
      if (!state_reg.ctrl_en)
      begin
         state_next.exch_timer = '0;
         state_next.was_active = 1'b0;
      end
      // controller output area toward the master
      if (running && state_reg.ctrl_en)
      begin
         state_next.to_master = base_output_area;
      end

      // table poll answered with fifteen bytes
      case (state_reg.poll)
         POLL_IDLE:
         begin
            if (poll_take)
            begin
               state_next.ptable = poll_table[TABLE_BITS-1:0];
               state_next.pseg = poll_segment[SEG_BITS-1:0];
               state_next.poll_bad = ((poll_table >> TABLE_BITS) != 8'h00) || ((poll_segment >> SEG_BITS) != 8'h00);
               state_next.byte_cnt = 4'h0;
               state_next.poll = POLL_ISSUE;
            end
         end
         POLL_ISSUE:
         begin
            mem_rd_en = 1'b1;
            state_next.poll = POLL_LOAD;
         end
         POLL_LOAD:
         begin
            // a segment outside the table answers with zero bytes so the master still gets a full reply
            state_next.reply = state_reg.poll_bad ? 8'h00 : mem_rd_data;
            state_next.poll = POLL_SEND;
         end
         POLL_SEND:
         begin
            if (reply_ready)
            begin
               if (state_reg.byte_cnt == 4'(`FGS_REPLY_BYTES - 1))
               begin
                  state_next.poll = POLL_IDLE;
                  ev[`FGS_IRQ_POLL_DONE] = 1'b1;
                  ev[`FGS_IRQ_BAD_POLL] = state_reg.poll_bad;
               end
               else
               begin
                  state_next.byte_cnt = state_reg.byte_cnt + 4'h1;
                  state_next.poll = POLL_ISSUE;
               end
            end
         end
         default:
         begin
            state_next.poll = POLL_IDLE;
         end
      endcase

      // bus slave: one wait cycle, read data are prepared during it
      state_next.ack = req & ~state_reg.ack;
      if (req && !state_reg.ack)
      begin
         state_next.rdata = 32'h0000_0000;
         if (avs_read)
         begin
            case (avs_address)
               `FGS_OFS_STATUS: state_next.rdata = {22'h0, 2'(state_reg.cfg), status_now};
               `FGS_OFS_CONFIG: state_next.rdata = {state_reg.rate, 7'h00, running, 7'h00, state_reg.station};
               `FGS_OFS_CTRL: state_next.rdata = {31'h0, state_reg.ctrl_en};
               `FGS_OFS_IRQ_STAT: state_next.rdata = 32'(state_reg.irq_stat);
               `FGS_OFS_IRQ_MASK: state_next.rdata = 32'(state_reg.irq_mask);
               `FGS_OFS_TBL_PTR: state_next.rdata = 32'(state_reg.tbl_ptr);
               default: state_next.rdata = 32'h0000_0000;
            endcase
         end
      end
      if (done && avs_write)
      begin
         case (avs_address)
            `FGS_OFS_CTRL: state_next.ctrl_en = avs_byteenable[0] ? avs_writedata[0] : state_reg.ctrl_en;
            `FGS_OFS_IRQ_MASK: state_next.irq_mask = (state_reg.irq_mask & ~IW'(wmask)) | IW'(wval);
            `FGS_OFS_TBL_PTR: state_next.tbl_ptr = (state_reg.tbl_ptr & ~ADDR_BITS'(wmask)) | ADDR_BITS'(wval);
            `FGS_OFS_TBL_DATA: state_next.tbl_ptr = avs_byteenable[0] ? state_reg.tbl_ptr + ADDR_BITS'(1) : state_reg.tbl_ptr;
            default:
            begin
            end
         endcase
      end
      // read clears status; a new event in the same cycle stays set
      if (done && avs_read && avs_address == `FGS_OFS_IRQ_STAT)
      begin
         state_next.irq_stat = ev;
      end
      else
      begin
         state_next.irq_stat = state_reg.irq_stat | ev;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_int_n)
   begin
      if (!rst_int_n)
      begin
         state_reg <= '0;
         state_reg.cfg <= CFG_START;
         state_reg.poll <= POLL_IDLE;
         state_reg.ctrl_en <= `FGS_CTRL_RESET;
         state_reg.irq_mask <= `FGS_MASK_RESET;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   fgs_table_mem #(
      .ADDR_BITS(ADDR_BITS)
   ) u_table_mem (
      .sys_clk(sys_clk),
      .wr_en(mem_wr_en),
      .wr_addr(state_reg.tbl_ptr),
      .wr_data(avs_writedata[7:0]),
      .rd_en(mem_rd_en),
      .rd_addr(mem_rd_addr),
      .rd_data(mem_rd_data)
   );

   assign irq = |(state_reg.irq_stat & state_reg.irq_mask);
   assign base_input_area = state_reg.to_base;
   assign master_in_data = state_reg.to_master;
   assign status_byte = {2'b00, exch_active, status_now[4:0]};
   assign bus_enable = running;
   assign station_address = state_reg.station;
   assign bit_rate_kbps = state_reg.rate;
   assign reply_valid = (state_reg.poll == POLL_SEND);
   assign reply_byte = state_reg.reply;
   assign reply_last = (state_reg.poll == POLL_SEND) && (state_reg.byte_cnt == 4'(`FGS_REPLY_BYTES - 1));
   assign power_led = state_reg.powered;
   assign run_led = running;
   assign error_led = (state_reg.cfg == CFG_FAULT) || (running && state_reg.was_active && !exch_active);
endmodule : fgs_gateway

// *** bench/fgs_gateway_chk.sv ***
// port checker for the fieldbus gateway, bound to its top module
`timescale 1ns/1ps
module fgs_gateway_chk (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire fgs_pkg::fgs_digit_t rate_selector_switch,
   input wire fgs_pkg::fgs_digit_t tens_digit_switch,
   input wire fgs_pkg::fgs_digit_t units_digit_switch,
   input wire logic bus_enable,
   input wire logic [6:0] station_address,
   input wire logic [9:0] bit_rate_kbps,
   input wire logic output_fault_bit,
   input wire logic input_fault_bit,
   input wire logic general_fault_bit,
   input wire logic diagnostic_bit,
   input wire logic run_bit,
   input wire fgs_pkg::fgs_byte_t status_byte,
   input wire logic master_out_valid,
   input wire fgs_pkg::fgs_points_t master_out_data,
   input wire fgs_pkg::fgs_points_t base_input_area,
   input wire logic poll_valid,
   input wire logic poll_ready,
   input wire logic reply_valid,
   input wire fgs_pkg::fgs_byte_t reply_byte,
   input wire logic reply_last,
   input wire logic reply_ready,
   input wire logic power_led,
   input wire logic run_led,
   input wire logic error_led
);
   import fgs_pkg::*;
   // settings above 8 map to no rate
   logic [9:0] rt [0:15] = '{1:10'h00a, 2:10'h014, 3:10'h032, 4:10'h07d, 5:10'h0fa, 6:10'h1f4, 7:10'h320,
      8:10'h3e8, default:10'h000};
   wire bad_rate = rate_selector_switch == 4'h0 || rate_selector_switch == 4'h9;
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);
   sequence s_take; poll_valid && poll_ready; endsequence
   sequence s_lead; (!poll_ready && !reply_valid) [*2] ##1 reply_valid; endsequence
   property p_rate; bus_enable |-> bit_rate_kbps == rt[rate_selector_switch]; endproperty
   a_rate: assert property (p_rate) else $error("bit rate off switch");
   property p_addr; bus_enable |-> station_address == tens_digit_switch * 7'h0a + units_digit_switch; endproperty
   a_addr: assert property (p_addr) else $error("station address off switches");
   property p_start; $rose(rst_n) && !bad_rate |-> ##[1:20] bus_enable; endproperty
   a_start: assert property (p_start) else $error("no automatic start");
   property p_stat; bus_enable |-> status_byte[7:6] == 2'b00 &&
      status_byte[4:0] == {run_bit, diagnostic_bit, general_fault_bit, input_fault_bit, output_fault_bit}; endproperty
   a_stat: assert property (p_stat) else $error("status led bits wrong");
   property p_exch; master_out_valid && bus_enable |=> status_byte[5] && base_input_area == $past(master_out_data);
   endproperty
   a_exch: assert property (p_exch) else $error("master data not passed on");
   property p_poll; s_take |=> s_lead; endproperty
   a_poll: assert property (p_poll) else $error("poll answer timing wrong");
   property p_hold; reply_valid && !reply_ready |=> reply_valid && $stable(reply_byte) && $stable(reply_last);
   endproperty
   a_hold: assert property (p_hold) else $error("reply byte dropped while stalled");
   property p_led; run_led == bus_enable && (!bus_enable || power_led); endproperty
   a_led: assert property (p_led) else $error("indicators disagree with state");
   property p_bad; $rose(rst_n) && bad_rate |-> !bus_enable [*8] ##[1:12] (error_led && !bus_enable); endproperty
   a_bad: assert property (p_bad) else $error("invalid rate not refused");
endmodule : fgs_gateway_chk
bind fgs_gateway fgs_gateway_chk u_chk (.*);

// *** bench/fgs_master_model.sv ***
// far-side model: bus master sending output data and polling the payload table
`timescale 1ns/1ps
module fgs_master_model (
   input wire logic sys_clk,
   output logic master_out_valid = 1'b0,
   output fgs_pkg::fgs_points_t master_out_data = '1,
   output logic poll_valid = 1'b0,
   output fgs_pkg::fgs_byte_t poll_table = 8'hff,
   output fgs_pkg::fgs_byte_t poll_segment = 8'hff,
   input wire logic poll_ready,
   input wire logic reply_valid,
   input wire fgs_pkg::fgs_byte_t reply_byte,
   input wire logic reply_last,
   output logic reply_ready = 1'b0
);
   import fgs_pkg::*;
   // slow mode stalls the reply stream every other cycle
   logic slow = 1'b0;
   int lastn = 0;
   fgs_byte_t got[$];
   always @(posedge sys_clk)
   begin
      reply_ready <= !slow || !reply_ready;
      if (reply_valid === 1'b1 && reply_ready === 1'b1)
      begin
         got.push_back(reply_byte);
         // first flagged byte only, so a stuck last flag shows up
         if (reply_last === 1'b1 && lastn == 0)
            lastn = got.size();
      end
   end
   task automatic send(input fgs_points_t dv);
      @(posedge sys_clk);
      master_out_valid <= 1'b1;
      master_out_data <= dv;
      @(posedge sys_clk);
      master_out_valid <= 1'b0;
      master_out_data <= ~dv;
   endtask : send
   task automatic poll(input fgs_byte_t t, input fgs_byte_t s);
      int n;
      n = 0;
      @(posedge sys_clk);
      poll_valid <= 1'b1;
      poll_table <= t;
      poll_segment <= s;
      do
      begin
         @(posedge sys_clk);
         n++;
      end
      while (poll_ready !== 1'b1 && n < 50);
      // released fields show junk, not the last request
      poll_valid <= 1'b0;
      poll_table <= ~t;
      poll_segment <= ~s;
   endtask : poll
endmodule : fgs_master_model

// *** bench/testbench.sv ***
// self-checking bench: switch decode, register bus, data exchange and payload polls
`timescale 1ns/1ps
module testbench;
   import fgs_pkg::*;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest, irq, bus_enable, power_led, run_led, error_led;
   logic [4:0] avs_address = 5'h00;
   logic [31:0] avs_writedata = 32'h0, avs_readdata;
   logic [3:0] avs_byteenable = 4'hf;
   fgs_digit_t rate_selector_switch = 4'h3, tens_digit_switch = 4'h0, units_digit_switch = 4'h0;
   logic [6:0] station_address;
   logic [9:0] bit_rate_kbps;
   logic output_fault_bit = 1'b0, input_fault_bit = 1'b0, general_fault_bit = 1'b0;
   logic diagnostic_bit = 1'b0, run_bit = 1'b0;
   fgs_byte_t status_byte, poll_table, poll_segment, reply_byte;
   logic master_out_valid, poll_valid, poll_ready, reply_valid, reply_last, reply_ready;
   fgs_points_t master_out_data, base_input_area, master_in_data, d, e;
   fgs_points_t base_output_area = '0;
   int err_count = 0, cmp_count = 0, seed = 32'h9d78a5d8, tbl[15];
   int rates[10] = '{0, 10, 20, 50, 125, 250, 500, 800, 1000, 0};
   logic [4:0] fb;
   fgs_gateway #(.EXCH_TIMEOUT_CYC(20)) u_dut (.*);
   fgs_master_model u_mst (.*);
   always #20 sys_clk = ~sys_clk;
   task automatic chk(input string nm, input logic [127:0] e, input logic [127:0] g);
      cmp_count++;
      if (g !== e)
      begin
         err_count++;
         $display("MISMATCH %s exp %0h got %0h", nm, e, g);
      end
   endtask : chk
   function automatic fgs_points_t rnd();
      return {$random(seed), $random(seed), $random(seed), $random(seed)};
   endfunction : rnd
   // one avalon transfer; a read is compared at the completing edge
   task automatic av(input logic w, input logic [4:0] a, input logic [31:0] wd, input logic [31:0] e,
      input string nm);
      int n;
      n = 0;
      @(posedge sys_clk);
      avs_address <= a;
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= wd;
      do
      begin
         @(posedge sys_clk);
         n++;
      end
      while (avs_waitrequest !== 1'b0 && n < 20);
      if (!w)
         chk(nm, e, avs_readdata);
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask : av
   task automatic boot(input int r, input int t, input int u);
      int n;
      n = 0;
      rst_n <= 1'b0;
      rate_selector_switch <= r[3:0];
      tens_digit_switch <= t[3:0];
      units_digit_switch <= u[3:0];
      repeat (3) @(posedge sys_clk);
      rst_n <= 1'b1;
      while (bus_enable !== 1'b1 && error_led !== 1'b1 && n < 40)
      begin
         @(posedge sys_clk);
         n++;
      end
      chk("bus_enable", r > 0 && r < 9, bus_enable);
      chk("error_led", r == 0 || r == 9, error_led);
      chk("power_led", 1'b1, power_led);
      chk("run_led", r > 0 && r < 9, run_led);
      if (r > 0 && r < 9)
      begin
         chk("bit_rate", rates[r], bit_rate_kbps);
         chk("station", t * 10 + u, station_address);
      end
   endtask : boot
   task automatic pollchk(input int t, input int s, input bit oor);
      int n;
      n = 0;
      u_mst.got.delete();
      u_mst.lastn = 0;
      u_mst.poll(t[7:0], s[7:0]);
      while (u_mst.got.size() < 15 && n < 200)
      begin
         @(posedge sys_clk);
         n++;
      end
      repeat (4) @(posedge sys_clk);
      chk("reply_count", 15, u_mst.got.size());
      chk("last_index", 15, u_mst.lastn);
      for (int i = 0; i < 15; i++)
         chk("reply_byte", oor ? 0 : tbl[i], u_mst.got[i]);
   endtask : pollchk
   task print_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : print_verdict
   initial
   begin
      fb = 5'($random(seed));
      for (int r = 0; r < 10; r++)
         boot(r, $unsigned($random(seed)) % 10, $unsigned($random(seed)) % 10);
      boot(3, 9, 9);
      {run_bit, diagnostic_bit, general_fault_bit, input_fault_bit, output_fault_bit} <= fb;
      // segment 2 of table 1, then an out-of-range table
      av(1'b1, 5'h14, 32'h0000_00a0, 32'h0, "");
      for (int i = 0; i < 15; i++)
      begin
         tbl[i] = $unsigned($random(seed)) % 256;
         av(1'b1, 5'h18, tbl[i], 32'h0, "");
      end
      u_mst.slow = 1'b1;
      pollchk(1, 2, 1'b0);
      u_mst.slow = 1'b0;
      pollchk(5, 0, 1'b1);
      av(1'b0, 5'h0c, 32'h0, 32'h0000_0011, "irq_stat_poll");
      av(1'b1, 5'h10, 32'h0000_0002, 32'h0, "");
      d = rnd();
      u_mst.send(d);
      @(posedge sys_clk);
      chk("base_input", d, base_input_area);
      chk("exchange_bit", 1'b1, status_byte[5]);
      chk("irq_raised", 1'b1, irq);
      av(1'b0, 5'h0c, 32'h0, 32'h0000_0002, "irq_stat_data");
      @(posedge sys_clk);
      chk("irq_cleared", 1'b0, irq);
      av(1'b1, 5'h10, 32'h0, 32'h0, "");
      e = rnd();
      u_mst.send(e);
      @(posedge sys_clk);
      chk("irq_masked", 1'b0, irq);
      av(1'b0, 5'h00, 32'h0, {22'h0, 2'h2, 3'h1, fb}, "status");
      av(1'b0, 5'h04, 32'h0, {10'h032, 7'h00, 1'b1, 7'h00, 7'h63}, "config");
      av(1'b1, 5'h1c, 32'hffff_ffff, 32'h0, "");
      av(1'b0, 5'h1c, 32'h0, 32'h0, "unmapped");
      d = rnd();
      base_output_area <= d;
      repeat (2) @(posedge sys_clk);
      chk("master_in", d, master_in_data);
      repeat (40) @(posedge sys_clk);
      chk("exchange_lost", 1'b0, status_byte[5]);
      chk("error_led_lost", 1'b1, error_led);
      av(1'b0, 5'h0c, 32'h0, 32'h0000_000a, "irq_stat_lost");
      // exchange disabled: output area frozen, lost-exchange lamp dropped
      av(1'b1, 5'h08, 32'h0, 32'h0, "");
      av(1'b0, 5'h08, 32'h0, 32'h0, "ctrl_off");
      base_output_area <= ~d;
      repeat (2) @(posedge sys_clk);
      chk("frozen_output", d, master_in_data);
      chk("base_input_kept", e, base_input_area);
      chk("error_led_off", 1'b0, error_led);
      av(1'b0, 5'h0c, 32'h0, 32'h0, "irq_stat_quiet");
      print_verdict;
   end
   initial
   begin
      repeat (6000) @(posedge sys_clk);
      err_count++;
      print_verdict;
   end
endmodule : testbench
